// File: rtl/uswba_pkg.sv
// Shared constants for the single-wire bit adapter, device end.
// Assumes a 100 MHz system clock; times are converted to cycle counts here.
package uswba_pkg;
    localparam int unsigned CLK_MHZ          = 100;
    // Longest low pulse still read as a written one (a longest time, rounds down)
    localparam int unsigned T_ONE_MAX_US     = 15;
    localparam int unsigned ONE_MAX_CYCLES   = T_ONE_MAX_US * CLK_MHZ;
    // Shortest low pulse read as a bus reset (a least time, rounds up)
    localparam int unsigned T_RESET_MIN_US   = 480;
    localparam int unsigned RESET_MIN_CYCLES = T_RESET_MIN_US * CLK_MHZ;
    // Time the line is held low when a zero is returned
    localparam int unsigned T_HOLD_ZERO_US   = 60;
    localparam int unsigned HOLD_ZERO_CYCLES = T_HOLD_ZERO_US * CLK_MHZ;
    localparam int unsigned CNT_W            = 24;
    localparam logic [CNT_W-1:0] CNT_MAX     = 24'hFF_FFFF;
    localparam int unsigned TXQ_WIDTH        = 1;
    localparam int unsigned TXQ_DEPTH        = 32;
    localparam logic [2:0] SYNC_RESET        = 3'h7;

    typedef enum logic [1:0] {
        USWBA_IDLE  = 2'b00,
        USWBA_LOW   = 2'b01,
        USWBA_DRIVE = 2'b10,
        USWBA_WAIT  = 2'b11
    } uswba_state_e;
endpackage

// File: rtl/uswba_stream_if.sv
// Valid/ready stream between the bit queue and the slot engine.
// Assumes both ends run on sys_clk.
`timescale 1ns/100ps
interface uswba_stream_if #(parameter int unsigned WIDTH = 1);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// File: rtl/uswba_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; the drain side may stall at will.
`timescale 1ns/100ps
module uswba_fifo
    import uswba_pkg::*;
#(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    uswba_stream_if.src           out_port
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    wr_ptr_next;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW-1:0]    rd_ptr_next;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             ready_reg;
    logic             ready_next;
    logic             push;
    logic             pop;

    assign push           = in_valid && in_ready;
    assign pop            = out_port.valid && out_port.ready;
    assign in_ready       = ready_reg;
    assign out_port.valid = (count_reg != '0);
    assign out_port.data  = mem[rd_ptr_reg];

    always_comb begin
        wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
        count_next  = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
        // Registered not-full flag, same timing as a compare on count_reg
        ready_next  = (count_next != DEPTH[AW:0]);
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            ready_reg  <= 1'b1;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
            ready_reg  <= ready_next;
        end
    end
endmodule

// File: rtl/uswba_top.sv
// Device end of a shared open-drain single-wire bus: decodes host low pulses
// and answers read slots from a queue of bits.
// Assumes an external pullup on the line and a pin wrapper that resolves
// shared_data_line from its input, output and output enable.
`timescale 1ns/100ps
module uswba_top
    import uswba_pkg::*;
#(
    parameter int unsigned RESET_CYCLES = RESET_MIN_CYCLES,
    parameter int unsigned HOLD_CYCLES  = HOLD_ZERO_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic shared_data_line_in,
    output logic      shared_data_line_out,
    output logic      shared_data_line_oe,
    input  wire logic supply_powered,
    input  wire logic tx_valid,
    input  wire logic tx_bit,
    output logic      tx_ready,
    output logic      rx_valid,
    output logic      rx_bit,
    output logic      bus_reset,
    output logic      conv_enable
);
    uswba_stream_if #(.WIDTH(TXQ_WIDTH)) txq_if ();

    uswba_fifo #(
        .WIDTH (TXQ_WIDTH),
        .DEPTH (TXQ_DEPTH)
    ) u_txq (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .in_valid (tx_valid),
        .in_data  (tx_bit),
        .in_ready (tx_ready),
        .out_port (txq_if.src)
    );

    logic [2:0]       line_sync_reg;
    logic [2:0]       pwr_sync_reg;
    logic             line_reg;
    logic             line_next;
    logic             pwr_reg;
    logic             pwr_next;
    uswba_state_e     state_reg;
    uswba_state_e     state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             oe_reg;
    logic             oe_next;
    logic             rx_valid_reg;
    logic             rx_valid_next;
    logic             rx_bit_reg;
    logic             rx_bit_next;
    logic             bus_reset_reg;
    logic             bus_reset_next;
    logic             pop;
    logic             fall;
    logic             rise;
    logic             long_low;

    // A pin change counts once the second and third stages agree
    always_comb begin
        line_next = (line_sync_reg[1] == line_sync_reg[2]) ? line_sync_reg[2] : line_reg;
        pwr_next  = (pwr_sync_reg[1] == pwr_sync_reg[2]) ? pwr_sync_reg[2] : pwr_reg;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            line_sync_reg <= SYNC_RESET;
            pwr_sync_reg  <= 3'h0;
            line_reg      <= 1'b1;
            pwr_reg       <= 1'b0;
        end else begin
            line_sync_reg <= {line_sync_reg[1:0], shared_data_line_in};
            pwr_sync_reg  <= {pwr_sync_reg[1:0], supply_powered};
            line_reg      <= line_next;
            pwr_reg       <= pwr_next;
        end
    end

    assign fall     = line_reg && !line_next;
    assign rise     = !line_reg && line_next;
    // The count reads one less than the low time, so thresholds are shifted by one
    assign long_low = (cnt_reg >= RESET_CYCLES[CNT_W-1:0] - 1'b1);
    assign pop      = (state_reg == USWBA_IDLE) && fall && txq_if.valid;
    assign txq_if.ready = pop;

    // Slot engine; power mode does not change it
    always_comb begin
        state_next     = state_reg;
        cnt_next       = (cnt_reg == CNT_MAX) ? cnt_reg : cnt_reg + 1'b1;
        oe_next        = oe_reg;
        rx_valid_next  = 1'b0;
        rx_bit_next    = rx_bit_reg;
        bus_reset_next = 1'b0;
        unique case (state_reg)
            USWBA_IDLE: begin
                // Released line is idle high; nothing is driven here
                oe_next  = 1'b0;
                cnt_next = '0;
                if (fall) begin
                    if (!txq_if.valid) begin
                        state_next = USWBA_LOW;
                    end else if (txq_if.data[0]) begin
                        state_next = USWBA_WAIT;
                    end else begin
                        state_next = USWBA_DRIVE;
                        oe_next    = 1'b1;
                    end
                end
            end
            USWBA_LOW: begin
                if (rise) begin
                    state_next = USWBA_IDLE;
                    if (long_low) begin
                        bus_reset_next = 1'b1;
                    end else begin
                        rx_valid_next = 1'b1;
                        rx_bit_next   = (cnt_reg < ONE_MAX_CYCLES[CNT_W-1:0]);
                    end
                end
            end
            USWBA_DRIVE: begin
                if (cnt_reg >= HOLD_CYCLES[CNT_W-1:0] - 1'b1) begin
                    oe_next    = 1'b0;
                    state_next = USWBA_WAIT;
                end
            end
            USWBA_WAIT: begin
                // End of a read slot; a held-over low may still be a reset
                if (!oe_reg && rise) begin
                    state_next     = USWBA_IDLE;
                    bus_reset_next = long_low;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg     <= USWBA_IDLE;
            cnt_reg       <= '0;
            oe_reg        <= 1'b0;
            rx_valid_reg  <= 1'b0;
            rx_bit_reg    <= 1'b0;
            bus_reset_reg <= 1'b0;
        end else begin
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            oe_reg        <= oe_next;
            rx_valid_reg  <= rx_valid_next;
            rx_bit_reg    <= rx_bit_next;
            bus_reset_reg <= bus_reset_next;
        end
    end

    assign shared_data_line_out = 1'b0;
    assign shared_data_line_oe  = oe_reg;
    assign rx_valid             = rx_valid_reg;
    assign rx_bit               = rx_bit_reg;
    assign bus_reset            = bus_reset_reg;
    // Continuous conversion enabled only when supply powered
    assign conv_enable          = pwr_reg;
endmodule

// File: dv/uswba_chk.sv
// Port checker for the single-wire device end.
// Assumes one clock domain; bound to every uswba_top instance.
`timescale 1ns/100ps
module uswba_chk
    import uswba_pkg::*;
#(
    parameter int unsigned RESET_CYCLES = RESET_MIN_CYCLES,
    parameter int unsigned HOLD_CYCLES  = HOLD_ZERO_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic shared_data_line_in,
    input wire logic shared_data_line_out,
    input wire logic shared_data_line_oe,
    input wire logic supply_powered,
    input wire logic tx_valid,
    input wire logic tx_bit,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic rx_bit,
    input wire logic bus_reset,
    input wire logic conv_enable
);
    logic [CNT_W-1:0] hold_reg;
    logic [CNT_W-1:0] hold_next;
    // Length of the current run of the device pulling low
    always_comb hold_next = shared_data_line_oe ? hold_reg + 1'b1 : '0;
    always_ff @(posedge sys_clk or negedge reset_n)
        if (!reset_n) hold_reg <= '0;
        else hold_reg <= hold_next;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_open_drain: assert property (shared_data_line_out == 1'b0)
        else $error("data output not low");
    a_hold_len: assert property ($fell(shared_data_line_oe) |->
        hold_reg == CNT_W'(HOLD_CYCLES)) else $error("zero hold length wrong");
    a_decode_excl: assert property (!(rx_valid && bus_reset))
        else $error("bit and reset together");
    a_decode_pulse: assert property (rx_valid || bus_reset |=> !rx_valid && !bus_reset)
        else $error("decode pulse too long");
    a_after_rise: assert property (rx_valid || bus_reset |-> $past(shared_data_line_in, 2))
        else $error("decode while line low");
    a_bit_holds: assert property (!rx_valid |-> rx_bit == $past(rx_bit))
        else $error("decoded bit moved");
    a_power_mode: assert property ($stable(supply_powered)[*6] |->
        conv_enable == supply_powered) else $error("mode not followed");
    c_one: cover property (rx_valid && rx_bit);
    c_reset: cover property (bus_reset);
    c_hold: cover property ($fell(shared_data_line_oe));
    c_zero: cover property (rx_valid && !rx_bit);
endmodule
bind uswba_top uswba_chk #(.RESET_CYCLES(RESET_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) u_chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .shared_data_line_in(shared_data_line_in),
    .shared_data_line_out(shared_data_line_out), .shared_data_line_oe(shared_data_line_oe),
    .supply_powered(supply_powered), .tx_valid(tx_valid), .tx_bit(tx_bit),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_bit(rx_bit), .bus_reset(bus_reset),
    .conv_enable(conv_enable));

// File: dv/uswba_host_model.sv
// Host on the shared line: an open-drain driver beside a pullup.
// Assumes the device pulls low only through dut_oe.
`timescale 1ns/100ps
module uswba_host_model (
    input  wire logic sys_clk,
    input  wire logic dut_oe,
    output wire logic line
);
    logic host_low = 1'b0;
    assign line = !(host_low || dut_oe === 1'b1);
    task automatic slot(input int low_cyc, input int rec_cyc, output logic lvl);
        @(posedge sys_clk);
        #1 host_low = 1'b1;
        repeat (low_cyc) @(posedge sys_clk);
        #1 host_low = 1'b0;
        repeat (9) @(posedge sys_clk);
        #1 lvl = line;
        repeat (rec_cyc) @(posedge sys_clk);
        #1;
    endtask
    // UART frame through the open-drain buffer; rx is what the line showed mid-bit
    task automatic uart_byte(input int bit_cyc, input logic [7:0] tx, output logic [7:0] rx);
        logic [9:0] frame;
        frame = {1'b1, tx, 1'b0};
        @(posedge sys_clk);
        for (int i = 0; i < 10; i++) begin
            #1 host_low = !frame[i];
            repeat (bit_cyc / 2) @(posedge sys_clk);
            #1 if (i > 0 && i < 9) rx[i - 1] = line;
            repeat (bit_cyc - bit_cyc / 2) @(posedge sys_clk);
        end
        #1 host_low = 1'b0;
    endtask
endmodule

// File: dv/tb_top.sv
// Bench for uswba_top: host slots, queued read bits, power mode.
// Assumes small RESET_CYCLES and HOLD_CYCLES; one-threshold is 1500.
`timescale 1ns/100ps
module tb_top;
    localparam int RST_C = 2000;
    // Zero hold long enough that a UART read of a zero echoes F0h
    localparam int HOLD_C = 1100;
    // UART bit time: 00h gives a reset, C0h a zero, FFh a one
    localparam int UART_BIT = 223;
    logic sys_clk, reset_n, supply_powered, tx_valid, tx_bit, lvl;
    logic [7:0] rx8;
    logic oe, tx_ready, rx_valid, rx_bit, bus_reset, conv_enable;
    wire  line;
    int   failures, total_checks, n;
    int   exp_q[$];
    logic bit_q[$];
    int   lens[4] = '{1500, 1501, RST_C - 1, RST_C};
    uswba_host_model host (.sys_clk(sys_clk), .dut_oe(oe), .line(line));
    uswba_top #(.RESET_CYCLES(RST_C), .HOLD_CYCLES(HOLD_C)) dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .shared_data_line_in(line),
        .shared_data_line_out(), .shared_data_line_oe(oe),
        .supply_powered(supply_powered), .tx_valid(tx_valid), .tx_bit(tx_bit),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_bit(rx_bit),
        .bus_reset(bus_reset), .conv_enable(conv_enable));
    task automatic check(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: %s got %b", $time, what, got);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Model: 0 zero, 1 one, 2 bus reset
    task automatic write_slot(input int len);
        exp_q.push_back(len <= 1500 ? 1 : (len < RST_C ? 0 : 2));
        host.slot(len, 12, lvl);
    endtask
    // UART-style write; the echo only shows that the device kept off the line
    task automatic uart_write(input logic [7:0] b, input int exp);
        exp_q.push_back(exp);
        host.uart_byte(UART_BIT, b, rx8);
        check(rx8 == b, 1'b1, "write echo");
    endtask
    always @(posedge sys_clk) begin
        if (reset_n && (rx_valid === 1'b1 || bus_reset === 1'b1)) begin
            n = exp_q.size() ? exp_q.pop_front() : 3;
            check(bus_reset, n == 2, "bus reset");
            if (n < 2) check(rx_bit, n == 1, "written bit");
        end
    end
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        $display("MISMATCH at %0t: run timed out", $time);
        failures++;
        complete_run();
    end
    initial begin
        reset_n = 1'b0;
        supply_powered = 1'b1;
        tx_valid = 1'b0;
        tx_bit = 1'b0;
        void'($urandom(32'h3a80));
        repeat (6) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        for (int p = 0; p < 2; p++) begin
            supply_powered = (p == 0);
            repeat (8) @(posedge sys_clk);
            #1 check(conv_enable, p == 0, "power mode");
            foreach (lens[i]) write_slot(lens[i]);
            repeat (4) write_slot($urandom_range(1900, 10));
        end
        write_slot(2 * RST_C);
        for (int k = 0; k < 40 && tx_ready === 1'b1; k++) begin
            tx_bit = 1'($urandom);
            tx_valid = 1'b1;
            bit_q.push_back(tx_bit);
            @(posedge sys_clk);
            #1;
        end
        tx_valid = 1'b0;
        check(bit_q.size() == 32, 1'b1, "queue depth");
        while (bit_q.size()) begin
            host.slot(3, HOLD_C + 10, lvl);
            check(lvl, bit_q.pop_front(), "returned bit");
        end
        check(tx_ready, 1'b1, "queue drained");
        uart_write(8'h00, 2);
        uart_write(8'hFF, 1);
        uart_write(8'hC0, 0);
        tx_valid = 1'b1;
        for (int q = 0; q < 2; q++) begin
            tx_bit = 1'(q);
            bit_q.push_back(tx_bit);
            @(posedge sys_clk);
            #1;
        end
        tx_valid = 1'b0;
        while (bit_q.size()) begin
            host.uart_byte(UART_BIT, 8'hFF, rx8);
            lvl = bit_q.pop_front();
            check(rx8 == (lvl ? 8'hFF : 8'hF0), 1'b1, "uart read byte");
            check(rx8 == 8'hFF, lvl, "uart read bit");
        end
        repeat (20) @(posedge sys_clk);
        check(exp_q.size() == 0, 1'b1, "missing decode");
        complete_run();
    end
endmodule
